// File: src/slpc_consts.vh
// constants for the serial loopback and pattern check block
`ifndef SLPC_CONSTS_VH
`define SLPC_CONSTS_VH
`define SLPC_LB_OFF       2'h0
`define SLPC_LB_PRE       2'h1
`define SLPC_LB_POST      2'h2
`define SLPC_PAT_PRBS7    2'h0
`define SLPC_PAT_LOWF     2'h1
`define SLPC_LOWF_WORD    10'h3E0
`define SLPC_PRBS_SEED    7'h7F
`define SLPC_PRBS_PERIOD  7'h7F
`define SLPC_ERR_HOLD     2'h3
`define SLPC_ERR_CNT_W    2
`endif

// File: src/slpc_prbs_gen.v
// prbs7 / low-frequency word generator, cleared by the transmit reset
`timescale 1ns/1ps
`include "slpc_consts.vh"
module slpc_prbs_gen #(
    parameter W = 10
) (
    input  wire         clk,
    input  wire         tx_rst,
    input  wire         lowf_sel,
    output reg  [W-1:0] word_q
);
    reg  [6:0]   lfsr_q;
    reg  [6:0]   l;
    reg  [W-1:0] w;
    integer      i;

    always @* begin
        l = lfsr_q;
        w = {W{1'b0}};
        for (i = 0; i < W; i = i + 1) begin
            w[i] = l[6];
            l    = {l[5:0], l[6] ^ l[5]};
        end
    end

    always @(posedge clk or posedge tx_rst) begin
        if (tx_rst) begin
            lfsr_q <= `SLPC_PRBS_SEED;
            word_q <= {W{1'b0}};
        end else begin
            lfsr_q <= l;
            word_q <= lowf_sel ? `SLPC_LOWF_WORD : w;
        end
    end
endmodule

// File: src/slpc_top.v
// serial loopback path plus prbs generator and verifier
`timescale 1ns/1ps
`include "slpc_consts.vh"
module slpc_top #(
    parameter W = 10
) (
    input  wire         SYS_CLK,
    input  wire         SYS_RST,
    input  wire         TX_DIG_RST,
    input  wire         RX_DIG_RST,
    input  wire         XAUI_MODE,
    input  wire [1:0]   LB_MODE,
    input  wire         SER_LB_EN,
    input  wire         BIST_EN,
    input  wire         LOWF_SEL,
    input  wire         PREEMPH_EN,
    input  wire         ALIGNED,
    input  wire [W-1:0] RX_RAW,
    input  wire [W-1:0] RX_CDR,
    input  wire [W-1:0] TX_FABRIC,
    output reg  [W-1:0] TX_OUT,
    output reg          TX_PREEMPH,
    output reg          TX_STAGES_EN,
    output reg  [W-1:0] RX_FABRIC,
    output reg          BIST_DONE,
    output reg          BIST_ERR
);
    // receive word, aligned and rx reset pins pass two flops before use
    reg  [W-1:0]               raw_m_q;
    reg  [W-1:0]               raw_q;
    reg  [W-1:0]               cdr_m_q;
    reg  [W-1:0]               cdr_q;
    reg                        al_m_q;
    reg                        al_q;
    reg                        rxr_m_q;
    reg                        rxr_q;
    reg  [W-1:0]               gen_q;
    wire [W-1:0]               gen_word;
    reg  [1:0]                 lb_q;
    reg  [6:0]                 ref_q;
    reg  [6:0]                 r;
    reg  [6:0]                 seed_s;
    reg  [6:0]                 seed_d;
    reg  [W-1:0]               exp_w;
    reg                        locked_q;
    reg  [6:0]                 cnt_q;
    reg                        seq_err_q;
    reg  [`SLPC_ERR_CNT_W-1:0] hold_q;
    wire [W-1:0]               rx_word;
    wire                       lowf_ok;
    wire                       mism;
    integer                    i;

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            raw_m_q <= {W{1'b0}};
            raw_q   <= {W{1'b0}};
            cdr_m_q <= {W{1'b0}};
            cdr_q   <= {W{1'b0}};
            al_m_q  <= 1'b0;
            al_q    <= 1'b0;
            // rx reset reads as held until the sync sees the pin
            rxr_m_q <= 1'b1;
            rxr_q   <= 1'b1;
        end else begin
            raw_m_q <= RX_RAW;
            raw_q   <= raw_m_q;
            cdr_m_q <= RX_CDR;
            cdr_q   <= cdr_m_q;
            al_m_q  <= ALIGNED;
            al_q    <= al_m_q;
            rxr_m_q <= RX_DIG_RST;
            rxr_q   <= rxr_m_q;
        end
    end

    // low frequency only at 10 bits
    assign lowf_ok = LOWF_SEL && (W == 10);

    slpc_prbs_gen #(
        .W (W)
    ) u_gen (
        .clk      (SYS_CLK),
        .tx_rst   (SYS_RST | TX_DIG_RST),
        .lowf_sel (lowf_ok),
        .word_q   (gen_word)
    );

    assign rx_word = (BIST_EN && SER_LB_EN) ? gen_word : cdr_q;

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lb_q         <= `SLPC_LB_OFF;
            TX_OUT       <= {W{1'b0}};
            TX_PREEMPH   <= 1'b0;
            TX_STAGES_EN <= 1'b1;
            RX_FABRIC    <= {W{1'b0}};
            gen_q        <= {W{1'b0}};
        end else begin
            // no loopback in xaui; mode set by reconfiguration only
            lb_q  <= XAUI_MODE ? `SLPC_LB_OFF : LB_MODE;
            // extra stage keeps bist words in step with other sources
            gen_q <= gen_word;
            if (lb_q == `SLPC_LB_PRE)
                TX_OUT <= raw_q;
            else if (lb_q == `SLPC_LB_POST)
                TX_OUT <= cdr_q;
            else if (BIST_EN)
                TX_OUT <= gen_q;
            else
                TX_OUT <= TX_FABRIC;
            TX_STAGES_EN <= (lb_q == `SLPC_LB_OFF);
            TX_PREEMPH   <= PREEMPH_EN && (lb_q != `SLPC_LB_PRE);
            RX_FABRIC    <= rx_word;
        end
    end

    // expected word from the self-synchronising reference lfsr
    always @* begin
        r     = ref_q;
        exp_w = {W{1'b0}};
        for (i = 0; i < W; i = i + 1) begin
            exp_w[i] = r[6];
            r        = {r[5:0], r[6] ^ r[5]};
        end
        // first aligned word holds the lfsr state bits msb-first
        seed_s = 7'h00;
        for (i = 0; i < 7; i = i + 1) begin
            seed_s[6-i] = rx_word[i];
        end
        // step past that word so the seed meets the next one
        seed_d = seed_s;
        for (i = 0; i < W; i = i + 1) begin
            seed_d = {seed_d[5:0], seed_d[6] ^ seed_d[5]};
        end
    end
    // no errors counted before the checker has locked
    assign mism = locked_q && (exp_w != rx_word);

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ref_q     <= `SLPC_PRBS_SEED;
            locked_q  <= 1'b0;
            cnt_q     <= 7'h00;
            seq_err_q <= 1'b0;
            hold_q    <= {`SLPC_ERR_CNT_W{1'b0}};
            BIST_DONE <= 1'b0;
            BIST_ERR  <= 1'b0;
        end else if (rxr_q || lowf_ok) begin
            // no status for low-frequency pattern or in rx reset
            ref_q     <= `SLPC_PRBS_SEED;
            locked_q  <= 1'b0;
            cnt_q     <= 7'h00;
            seq_err_q <= 1'b0;
            hold_q    <= {`SLPC_ERR_CNT_W{1'b0}};
            BIST_DONE <= 1'b0;
            BIST_ERR  <= 1'b0;
        end else if (!BIST_EN) begin
            // checker idles; flags stay until rx reset, system reset or low-frequency select
            ref_q     <= `SLPC_PRBS_SEED;
            locked_q  <= 1'b0;
            cnt_q     <= 7'h00;
            seq_err_q <= 1'b0;
            hold_q    <= {`SLPC_ERR_CNT_W{1'b0}};
        end else if (al_q) begin
            // seed from the first aligned word, then free-run
            if (!locked_q) begin
                ref_q    <= seed_d;
                locked_q <= 1'b1;
            end else begin
                ref_q <= r;
            end
            if (locked_q) begin
                if (cnt_q == `SLPC_PRBS_PERIOD - 7'h01) begin
                    cnt_q <= 7'h00;
                    // done after one full cycle, sticky
                    BIST_DONE <= 1'b1;
                    if (!seq_err_q && !mism && hold_q == 2'h0)
                        BIST_ERR <= 1'b0;
                    seq_err_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + 7'h01;
                    if (mism)
                        seq_err_q <= 1'b1;
                end
            end
            // error held at least three cycles
            if (BIST_DONE && mism) begin
                BIST_ERR <= 1'b1;
                hold_q   <= `SLPC_ERR_HOLD;
            end else if (hold_q != 2'h0) begin
                // minimum-width timer ages on aligned words only
                hold_q <= hold_q - 2'h1;
            end
        end
    end
endmodule

// File: test/slpc_far_end.sv
// far-end transceiver model driving raw and retimed receive words
`timescale 1ns/1ps
module slpc_far_end (
    input  wire       clk,
    input  wire [9:0] word,
    output reg  [9:0] rx_raw,
    output reg  [9:0] rx_cdr
);
    // retimed copy lags the line by one clock, as a recovered clock would
    always @* rx_raw = word;
    always @(posedge clk) rx_cdr <= word;
endmodule

// File: test/slpc_top_props.sv
// concurrent checks on loopback routing and verifier flags
`timescale 1ns/1ps
module slpc_top_props #(
    parameter W = 10
) (
    input wire         SYS_CLK,
    input wire         SYS_RST,
    input wire         RX_DIG_RST,
    input wire         XAUI_MODE,
    input wire [1:0]   LB_MODE,
    input wire         LOWF_SEL,
    input wire [W-1:0] RX_RAW,
    input wire [W-1:0] RX_CDR,
    input wire [W-1:0] TX_OUT,
    input wire         TX_PREEMPH,
    input wire         TX_STAGES_EN,
    input wire         BIST_DONE,
    input wire         BIST_ERR
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    wire pre = LB_MODE == 2'h1 && !XAUI_MODE;
    wire post = LB_MODE == 2'h2 && !XAUI_MODE;
    a_xaui_no_lb: assert property (XAUI_MODE[*4] |-> TX_STAGES_EN)
        else $error("loopback seen in xaui mode");
    a_pre_raw: assert property (pre[*6] |-> TX_OUT == $past(RX_RAW, 3))
        else $error("pre loopback word wrong");
    a_post_cdr: assert property (post[*6] |-> TX_OUT == $past(RX_CDR, 3))
        else $error("post loopback word wrong");
    a_lb_stages: assert property ((pre || post)[*3] |-> !TX_STAGES_EN)
        else $error("tx stages on in loopback");
    a_pre_no_emph: assert property (pre[*3] |-> !TX_PREEMPH)
        else $error("pre-emphasis in pre loopback");
    a_lowf_unchecked: assert property (
        LOWF_SEL[*2] |-> !BIST_DONE && !BIST_ERR)
        else $error("status flags up for low-freq pattern");
    a_done_hold: assert property ($fell(BIST_DONE) |-> $past(RX_DIG_RST)
        || $past(RX_DIG_RST, 2) || $past(RX_DIG_RST, 3))
        else $error("done dropped without rx reset");
    a_err_min: assert property (
        $rose(BIST_ERR) && !RX_DIG_RST |-> BIST_ERR[*3])
        else $error("error pulse too short");
    a_rst_quiet: assert property (RX_DIG_RST[*4] |-> !BIST_DONE && !BIST_ERR)
        else $error("flags high during rx reset");
endmodule
bind slpc_top slpc_top_props #(.W(W)) u_props (.SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST), .RX_DIG_RST(RX_DIG_RST), .XAUI_MODE(XAUI_MODE),
    .LB_MODE(LB_MODE), .LOWF_SEL(LOWF_SEL), .RX_RAW(RX_RAW), .RX_CDR(RX_CDR),
    .TX_OUT(TX_OUT), .TX_PREEMPH(TX_PREEMPH), .TX_STAGES_EN(TX_STAGES_EN),
    .BIST_DONE(BIST_DONE), .BIST_ERR(BIST_ERR));

// File: test/tb.sv
// bench for loopback routing and pattern verifier status
`timescale 1ns/1ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb;
    reg        clk, rst, txr, rxr, xaui, ser, bist, lowf, pe, al;
    reg  [1:0] lb;
    reg  [9:0] word, txf;
    wire [9:0] raw, cdr, tx_out, rx_fab;
    wire       tpe, tse, done, err;
    integer    n_errors = 0, compares = 0;
    slpc_far_end far (.clk(clk), .word(word), .rx_raw(raw), .rx_cdr(cdr));
    slpc_top #(.W(10)) DUT (.SYS_CLK(clk), .SYS_RST(rst), .TX_DIG_RST(txr),
        .RX_DIG_RST(rxr), .XAUI_MODE(xaui), .LB_MODE(lb), .SER_LB_EN(ser),
        .BIST_EN(bist), .LOWF_SEL(lowf), .PREEMPH_EN(pe), .ALIGNED(al),
        .RX_RAW(raw), .RX_CDR(cdr), .TX_FABRIC(txf), .TX_OUT(tx_out),
        .TX_PREEMPH(tpe), .TX_STAGES_EN(tse), .RX_FABRIC(rx_fab),
        .BIST_DONE(done), .BIST_ERR(err));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task results;
        begin
            $display("errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // bounded wait; a hang counts as a mismatch
    task wait_flag(input s, input v, input integer lim);
        integer k;
        begin
            for (k = 0; k < lim && (s ? err : done) !== v; k++) @(posedge clk);
            #1;
            `CHK("flag wait", v, s ? err : done)
            if ((s ? err : done) !== v) results;
        end
    endtask
    // mode changes only between checks, like a reconfiguration
    task mode(input x, input [1:0] m, input [9:0] w);
        begin
            @(posedge clk);
            xaui <= x;
            lb <= m;
            word <= w;
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    initial begin
        {rst, txr, rxr, xaui, ser, bist, lowf, pe, al} = 9'h102;
        lb = 2'h0;
        word = 10'h000;
        txf = 10'h15A;
        repeat (8) @(posedge clk);
        rst <= 0;
        mode(0, 2'h1, 10'h2A5);
        `CHK("pre tx_out", word, tx_out)
        `CHK("pre rx_fab", word, rx_fab)
        `CHK("pre stages", 1'b0, tse)
        `CHK("pre emph", 1'b0, tpe)
        mode(0, 2'h2, 10'h0F3);
        `CHK("post tx_out", word, tx_out)
        `CHK("post emph", 1'b1, tpe)
        mode(1, 2'h1, 10'h311);
        `CHK("xaui stages", 1'b1, tse)
        `CHK("xaui tx_out", txf, tx_out)
        mode(0, 2'h0, 10'h000);
        {ser, bist, al} <= 3'h7;
        wait_flag(0, 1, 400);
        repeat (20) @(posedge clk);
        #1;
        `CHK("err clean", 1'b0, err)
        ser <= 0;
        wait_flag(1, 1, 20);
        ser <= 1;
        `CHK("done held", 1'b1, done)
        wait_flag(1, 0, 400);
        {txr, rxr} <= 2'h3;
        repeat (4) @(posedge clk);
        #1;
        `CHK("rst done", 1'b0, done)
        `CHK("rst err", 1'b0, err)
        {txr, rxr} <= 2'h0;
        wait_flag(0, 1, 400);
        {lowf, rxr} <= 2'h3;
        repeat (4) @(posedge clk);
        rxr <= 0;
        repeat (300) @(posedge clk);
        #1;
        `CHK("lowf done", 1'b0, done)
        `CHK("lowf err", 1'b0, err)
        `CHK("lowf tx_out", 10'h3E0, tx_out)
        `CHK("lowf rx_fab", 10'h3E0, rx_fab)
        results;
    end
endmodule
